// File: rtl/flow_manager_pkg.sv
// Purpose: Shared constants of the two-channel data flow manager
// Assumes: 8-bit register port, 4-bit peripheral identifiers
// Notes:   Offsets are word indexes on the register port

package flow_manager_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_FLOW_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_CHANNEL_STATUS = 3'h1;
    localparam logic [2:0] ADDR_CHANNEL_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_CHAN0_DESC = 3'h3;
    localparam logic [2:0] ADDR_CHAN1_DESC = 3'h4;
    localparam logic [2:0] ADDR_CRC_DATA = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // flow_control_reg
    localparam int FC_ENABLE = 0;
    localparam int FC_CRC_EN = 1;
    localparam int FC_ABORT_MODE = 2;
    localparam int FC_PRIO_LO = 3;
    // channel_control_reg, channel c at base + c
    localparam int CC_ABORT = 0;
    localparam int CC_ACK = 2;
    localparam int CC_IRQ_EN = 4;
    // channel_status_reg
    localparam int ST_BUSY = 0;
    localparam int ST_EOF = 2;
    localparam int ST_READY = 4;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [1:0] PRIO_EQUAL = 2'h0;
    localparam logic [1:0] PRIO_CHAN0 = 2'h1;
    localparam logic [1:0] PRIO_CHAN1 = 2'h2;
    localparam logic [3:0] NULL_DEVICE_ID = 4'hF;
    localparam logic [3:0] MAX_SIZE_EXP = 4'hD;
    localparam logic [2:0] DESC_SOURCE = 3'h0;
    localparam logic [2:0] DESC_DEST = 3'h1;
    localparam logic [2:0] DESC_EXP = 3'h2;
    localparam logic [2:0] DESC_SIZE_HIGH = 3'h3;
    localparam logic [2:0] DESC_SIZE_LOW = 3'h4;
    localparam logic [15:0] CRC_RESET = 16'h0000;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CONTINUOUS_SIZE = 16'h0000;

endpackage

// File: rtl/crc16_byte.sv
// Purpose: One byte step of the CRC-16 (x^16 + x^15 + x^2 + 1)
// Assumes: Data bits enter MSB first
// Notes:   Purely combinational

`timescale 1ns/1ns

module crc16_byte
    import flow_manager_pkg::*;
(
    // Running value and new byte
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data_in,
    // Value after the byte
    output logic [15:0] crc_out
);

    always_comb begin
        logic [15:0] c;
        logic fb;
        c = crc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ data_in[i];
            c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        crc_out = c;
    end

endmodule

// File: rtl/flow_manager.sv
// Purpose: Two-channel flow manager moving bytes between peripherals
// Assumes: Peripheral ready lines and read data come from logic on CLK
// Notes:   One byte per cycle on the bus; the write side follows one cycle later
//
// Functional notes
// - Two independent channels share one byte bus
// - Nothing runs until enable bit set
// - Fifth descriptor byte written enables the channel
// - Move only when source and destination ready
// - Descriptor: source, dest, exponent, size high, low
// - Packet is two to exponent, capped 8192
// - Size counts packets; zero means continuous
// - Identifiers select peripherals; fifteen is null
// - CRC-16 on channel 0 bytes, MSB first
// - CRC resets zero, seeded MSB first; restartable
// - Two CRC reads give result, MSB first
// - New flow keeps the CRC accumulator
// - Null destination always ready, discards bytes
// - Null source always ready, sends seed bytes
// - Equal priority alternates bytes between channels
// - Priority field: equal, channel 0, channel 1
// - Priority changes take effect immediately
// - Busy set on descriptor, cleared on end
// - Status shows live source and destination ready
// - Abort stops after byte or packet, sets end
// - Abort during descriptor discards it, no end flag
// - Descriptor port reads remaining packets after abort
// - End flags request interrupts when enabled
// - Software clears end flag by acknowledge only
//
// Local design decisions: the strobed register port and the address map.

`timescale 1ns/1ns

module flow_manager
    import flow_manager_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Peripheral ready lines, indexed by identifier
    input wire logic [15:0] SRC_READY,
    input wire logic [15:0] DST_READY,
    // Byte bus, source side
    output logic [3:0] BUS_SRC_ID,
    output logic BUS_SRC_TAKE,
    input wire logic [7:0] BUS_RD_DATA,
    // Byte bus, destination side
    output logic [3:0] BUS_DST_ID,
    output logic BUS_DST_PUT,
    output logic [7:0] BUS_WR_DATA,
    // End-of-flow interrupt requests
    output logic [1:0] EOF_IRQ
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic enable_reg;
    logic crc_en_reg;
    logic abort_mode_reg;
    logic [1:0] prio_reg;
    logic [1:0] irq_en_reg;
    logic [1:0] eof_reg;
    logic [1:0] busy_reg;
    logic [1:0] pend_abort_reg;
    logic [1:0] null_sel_reg;
    logic [1:0] rem_rd_sel_reg;
    logic [2:0] desc_cnt_reg [2];
    logic [3:0] sid_reg [2];
    logic [3:0] did_reg [2];
    logic [3:0] exp_reg [2];
    logic [7:0] size_high_reg [2];
    logic [15:0] size_reg [2];
    logic [15:0] rem_reg [2];
    logic [12:0] byte_cnt_reg [2];
    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic [15:0] seed_reg;
    logic crc_wr_sel_reg;
    logic crc_rd_sel_reg;
    logic last_gnt_reg;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic wr_fc;
    logic wr_cc;
    logic wr_crc;
    logic rd_crc;
    logic [1:0] wr_desc;
    logic [1:0] rd_desc;
    logic [1:0] abort_wr;
    logic [1:0] abort_imm;
    logic [1:0] ack_wr;

    assign wr_fc = WR && (ADDR == ADDR_FLOW_CONTROL);
    assign wr_cc = WR && (ADDR == ADDR_CHANNEL_CONTROL);
    assign wr_crc = WR && (ADDR == ADDR_CRC_DATA);
    assign rd_crc = RD && (ADDR == ADDR_CRC_DATA);
    assign wr_desc[0] = WR && (ADDR == ADDR_CHAN0_DESC);
    assign wr_desc[1] = WR && (ADDR == ADDR_CHAN1_DESC);
    assign rd_desc[0] = RD && (ADDR == ADDR_CHAN0_DESC);
    assign rd_desc[1] = RD && (ADDR == ADDR_CHAN1_DESC);

    // ------------------------------------------------------------
    // Channel readiness and arbitration
    // ------------------------------------------------------------
    logic [1:0] src_rdy;
    logic [1:0] dst_rdy;
    logic [1:0] req;
    logic [1:0] pkt_last;
    logic [1:0] flow_last;
    logic [1:0] end_evt;
    logic xfer_go;
    logic xfer_ch;
    logic [7:0] xfer_data;
    logic [12:0] pkt_mask [2];

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            // Null device is always ready on both sides
            src_rdy[c] = (sid_reg[c] == NULL_DEVICE_ID) || SRC_READY[sid_reg[c]];
            dst_rdy[c] = (did_reg[c] == NULL_DEVICE_ID) || DST_READY[did_reg[c]];
            // Clock gate modelled as a global enable
            req[c] = enable_reg && busy_reg[c] && src_rdy[c] && dst_rdy[c];
            pkt_mask[c] = 13'((14'h0001 << exp_reg[c]) - 14'h0001);
            pkt_last[c] = (byte_cnt_reg[c] == pkt_mask[c]);
            flow_last[c] = (size_reg[c] != CONTINUOUS_SIZE) && (rem_reg[c] == 16'h0001);
            abort_wr[c] = wr_cc && WDATA[CC_ABORT + c];
            ack_wr[c] = wr_cc && WDATA[CC_ACK + c];
            abort_imm[c] = abort_wr[c] && busy_reg[c] && !abort_mode_reg;
        end
    end

    always_comb begin
        xfer_go = |req;
        case (prio_reg)
            PRIO_CHAN0: xfer_ch = !req[0];
            PRIO_CHAN1: xfer_ch = req[1];
            default: xfer_ch = (req == 2'b11) ? !last_gnt_reg : req[1];
        endcase
    end

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            end_evt[c] = abort_imm[c]
                || (xfer_go && (xfer_ch == c[0]) && pkt_last[c]
                    && (flow_last[c] || pend_abort_reg[c]));
        end
    end

    // Null source feeds the seed MSB first
    assign xfer_data = (sid_reg[xfer_ch] != NULL_DEVICE_ID) ? BUS_RD_DATA
        : (null_sel_reg[xfer_ch] ? seed_reg[7:0] : seed_reg[15:8]);
    assign BUS_SRC_ID = sid_reg[xfer_ch];
    assign BUS_SRC_TAKE = xfer_go && (sid_reg[xfer_ch] != NULL_DEVICE_ID);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            last_gnt_reg <= 1'b0;
        end else if (xfer_go) begin
            last_gnt_reg <= xfer_ch;
        end
    end

    // ------------------------------------------------------------
    // Destination write stage
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            BUS_DST_PUT <= 1'b0;
            BUS_DST_ID <= 4'h0;
            BUS_WR_DATA <= 8'h00;
        end else begin
            // Null destination swallows the byte
            BUS_DST_PUT <= xfer_go && (did_reg[xfer_ch] != NULL_DEVICE_ID);
            if (xfer_go) begin
                BUS_DST_ID <= did_reg[xfer_ch];
                BUS_WR_DATA <= xfer_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Global control
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            enable_reg <= 1'b0;
            crc_en_reg <= 1'b0;
            abort_mode_reg <= 1'b0;
            prio_reg <= PRIO_EQUAL;
            irq_en_reg <= 2'b00;
        end else begin
            if (wr_fc) begin
                enable_reg <= WDATA[FC_ENABLE];
                crc_en_reg <= WDATA[FC_CRC_EN];
                abort_mode_reg <= WDATA[FC_ABORT_MODE];
                prio_reg <= WDATA[FC_PRIO_LO +: 2];
            end
            if (wr_cc) begin
                irq_en_reg <= WDATA[CC_IRQ_EN +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // Descriptors, flow counting and abort
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            busy_reg <= 2'b00;
            pend_abort_reg <= 2'b00;
            null_sel_reg <= 2'b00;
            for (int c = 0; c < 2; c++) begin
                desc_cnt_reg[c] <= DESC_SOURCE;
                sid_reg[c] <= 4'h0;
                did_reg[c] <= 4'h0;
                exp_reg[c] <= 4'h0;
                size_high_reg[c] <= 8'h00;
                size_reg[c] <= 16'h0000;
                rem_reg[c] <= 16'h0000;
                byte_cnt_reg[c] <= 13'h0000;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (xfer_go && (xfer_ch == c[0])) begin
                    null_sel_reg[c] <= !null_sel_reg[c];
                    if (pkt_last[c]) begin
                        byte_cnt_reg[c] <= 13'h0000;
                        if (size_reg[c] != CONTINUOUS_SIZE) begin
                            rem_reg[c] <= rem_reg[c] - 16'h0001;
                        end
                    end else begin
                        byte_cnt_reg[c] <= byte_cnt_reg[c] + 13'h0001;
                    end
                end
                if (end_evt[c]) begin
                    busy_reg[c] <= 1'b0;
                    pend_abort_reg[c] <= 1'b0;
                end else if (abort_wr[c] && busy_reg[c]) begin
                    pend_abort_reg[c] <= 1'b1;
                end
                if (abort_wr[c] && !busy_reg[c]) begin
                    // Partial descriptor dropped; idle channel unchanged
                    desc_cnt_reg[c] <= DESC_SOURCE;
                end else if (wr_desc[c] && enable_reg && !busy_reg[c]) begin
                    case (desc_cnt_reg[c])
                        DESC_SOURCE: sid_reg[c] <= WDATA[3:0];
                        DESC_DEST: did_reg[c] <= WDATA[3:0];
                        DESC_EXP: begin
                            exp_reg[c] <= (WDATA > 8'(MAX_SIZE_EXP)) ? MAX_SIZE_EXP
                                : WDATA[3:0];
                        end
                        DESC_SIZE_HIGH: size_high_reg[c] <= WDATA;
                        default: begin
                            size_reg[c] <= {size_high_reg[c], WDATA};
                            rem_reg[c] <= {size_high_reg[c], WDATA};
                            byte_cnt_reg[c] <= 13'h0000;
                            null_sel_reg[c] <= 1'b0;
                            busy_reg[c] <= 1'b1;
                        end
                    endcase
                    desc_cnt_reg[c] <= (desc_cnt_reg[c] == DESC_SIZE_LOW) ? DESC_SOURCE
                        : desc_cnt_reg[c] + 3'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // End-of-flow flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            eof_reg <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (end_evt[c]) begin
                    eof_reg[c] <= 1'b1;
                end else if (ack_wr[c]) begin
                    eof_reg[c] <= 1'b0;
                end
            end
        end
    end

    assign EOF_IRQ = eof_reg & irq_en_reg;

    // ------------------------------------------------------------
    // CRC engine
    // ------------------------------------------------------------
    crc16_byte u_crc (
        .crc_in(crc_reg),
        .data_in(xfer_data),
        .crc_out(crc_next)
    );

    always_ff @(posedge CLK) begin
        if (RESET) begin
            crc_reg <= CRC_RESET;
            seed_reg <= CRC_RESET;
            crc_wr_sel_reg <= 1'b0;
        end else begin
            if (wr_crc) begin
                if (!crc_wr_sel_reg) begin
                    crc_reg[15:8] <= WDATA;
                    seed_reg[15:8] <= WDATA;
                end else begin
                    crc_reg[7:0] <= WDATA;
                    seed_reg[7:0] <= WDATA;
                end
            end else if (crc_en_reg && xfer_go && !xfer_ch) begin
                crc_reg <= crc_next;
            end
            if (wr_fc && !WDATA[FC_CRC_EN]) begin
                crc_wr_sel_reg <= 1'b0;
            end else if (wr_crc) begin
                crc_wr_sel_reg <= !crc_wr_sel_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            crc_rd_sel_reg <= 1'b0;
            rem_rd_sel_reg <= 2'b00;
        end else begin
            if (wr_fc && !WDATA[FC_CRC_EN]) begin
                crc_rd_sel_reg <= 1'b0;
            end else if (rd_crc) begin
                crc_rd_sel_reg <= !crc_rd_sel_reg;
            end
            for (int c = 0; c < 2; c++) begin
                if (busy_reg[c]) begin
                    rem_rd_sel_reg[c] <= 1'b0;
                end else if (rd_desc[c]) begin
                    rem_rd_sel_reg[c] <= !rem_rd_sel_reg[c];
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                ADDR_FLOW_CONTROL: begin
                    RDATA <= {3'h0, prio_reg, abort_mode_reg, crc_en_reg, enable_reg};
                end
                ADDR_CHANNEL_STATUS: begin
                    RDATA <= {dst_rdy[1], src_rdy[1], dst_rdy[0], src_rdy[0],
                        eof_reg, busy_reg};
                end
                ADDR_CHANNEL_CONTROL: begin
                    // Abort and acknowledge bits read as zero
                    RDATA <= {2'h0, irq_en_reg, 4'h0};
                end
                ADDR_CHAN0_DESC: begin
                    RDATA <= rem_rd_sel_reg[0] ? rem_reg[0][7:0] : rem_reg[0][15:8];
                end
                ADDR_CHAN1_DESC: begin
                    RDATA <= rem_rd_sel_reg[1] ? rem_reg[1][7:0] : rem_reg[1][15:8];
                end
                ADDR_CRC_DATA: begin
                    RDATA <= crc_rd_sel_reg ? crc_reg[7:0] : crc_reg[15:8];
                end
                default: RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_gated_idle: assert property (!enable_reg |-> !xfer_go)
        else $error("byte moved while disabled");
    a_desc_starts: assert property (wr_desc[0] && enable_reg && !busy_reg[0]
        && !abort_wr[0] && desc_cnt_reg[0] == DESC_SIZE_LOW |=> busy_reg[0])
        else $error("fifth byte did not start channel");
    a_move_ready: assert property (xfer_go |-> src_rdy[xfer_ch] && dst_rdy[xfer_ch])
        else $error("move without both ready");
    a_put_follows: assert property (xfer_go && did_reg[xfer_ch] != NULL_DEVICE_ID
        |=> BUS_DST_PUT && BUS_WR_DATA == $past(xfer_data))
        else $error("destination write missing");
    a_prio_zero: assert property (prio_reg == PRIO_CHAN0 && req[0] |-> !xfer_ch)
        else $error("channel 0 priority ignored");
    a_share_alternate: assert property ((prio_reg == PRIO_EQUAL && req == 2'b11)
        ##1 (prio_reg == PRIO_EQUAL && req == 2'b11) |-> xfer_ch != $past(xfer_ch))
        else $error("equal priority did not alternate");
    a_abort_now: assert property (abort_imm[0] |=> !busy_reg[0] && eof_reg[0])
        else $error("immediate abort failed");
    a_partial_drop: assert property (abort_wr[0] && !busy_reg[0] && desc_cnt_reg[0] != 3'h0
        |=> desc_cnt_reg[0] == DESC_SOURCE && !$rose(eof_reg[0]))
        else $error("partial descriptor abort wrong");
    a_eof_ack: assert property (eof_reg[0] && ack_wr[0] && !end_evt[0] |=> !eof_reg[0])
        else $error("acknowledge did not clear flag");
    a_flow_end: assert property (xfer_go && !xfer_ch && pkt_last[0] && flow_last[0]
        |=> !busy_reg[0] && eof_reg[0] && rem_reg[0] == 16'h0000)
        else $error("finite flow did not end");

endmodule

// File: testbench/periph_model.sv
// Purpose: Peripheral sources and sinks on the byte bus
// Assumes: Stall mask from the bench, one bit per identifier
// Notes:   Each source sends its own incrementing byte count

`timescale 1ns/1ns

module periph_model (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Bench control
    input wire logic [15:0] STALL,
    // Byte bus
    input wire logic [3:0] BUS_SRC_ID,
    input wire logic BUS_SRC_TAKE,
    output logic [15:0] SRC_READY,
    output logic [15:0] DST_READY,
    output logic [7:0] BUS_RD_DATA
);
    logic [7:0] cnt_reg [16];

    assign SRC_READY = ~STALL;
    assign DST_READY = ~STALL;
    // Byte is valid only in the take cycle
    assign BUS_RD_DATA = BUS_SRC_TAKE ? cnt_reg[BUS_SRC_ID] : ~cnt_reg[BUS_SRC_ID];

    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < 16; i++) begin
                cnt_reg[i] <= 8'h00;
            end
        end else if (BUS_SRC_TAKE) begin
            cnt_reg[BUS_SRC_ID] <= cnt_reg[BUS_SRC_ID] + 8'h01;
        end
    end
endmodule

// File: testbench/flow_manager_tb.sv
// Purpose: Self-checking bench of the flow manager
// Assumes: Peripheral model on the byte bus
// Notes:   Model counts bytes per source and keeps a CRC of its own

`timescale 1ns/1ns

module flow_manager_tb
    import flow_manager_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, rd_data, wr_data;
    logic [15:0] src_ready, dst_ready;
    logic [15:0] stall = 16'h0000;
    logic [3:0] src_id, dst_id;
    logic take, put, rnd_on, crc_on;
    logic [1:0] eof_irq;
    logic [3:0] cur_src, cur_dst;
    logic [15:0] crc_m = 16'h0000;
    logic [31:0] seed = 32'h6D51;
    int num_errors = 0;
    int samples_checked = 0;
    int put_cnt = 0;
    int take_cnt = 0;
    int exp_cnt [16] = '{default: 0};

    always #50 clk = ~clk;

    flow_manager DUT (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SRC_READY(src_ready), .DST_READY(dst_ready),
        .BUS_SRC_ID(src_id), .BUS_SRC_TAKE(take), .BUS_RD_DATA(rd_data),
        .BUS_DST_ID(dst_id), .BUS_DST_PUT(put), .BUS_WR_DATA(wr_data), .EOF_IRQ(eof_irq));
    periph_model peri (.CLK(clk), .RESET(reset), .STALL(stall), .BUS_SRC_ID(src_id),
        .BUS_SRC_TAKE(take), .SRC_READY(src_ready), .DST_READY(dst_ready),
        .BUS_RD_DATA(rd_data));

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        end
        return r;
    endfunction

    // Null source repeats the seed written earlier, MSB first
    function automatic logic [7:0] exp_byte(input logic [3:0] s);
        if (s == 4'hF) begin
            return exp_cnt[15][0] ? 8'h34 : 8'h12;
        end
        return exp_cnt[s][7:0];
    endfunction

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic desc(input logic [2:0] a, input logic [7:0] s, t, e, input logic [15:0] n);
        wr_reg(a, s);
        wr_reg(a, t);
        wr_reg(a, e);
        wr_reg(a, n[15:8]);
        wr_reg(a, n[7:0]);
    endtask

    // Polls status until the busy bit b drops, bounded
    task automatic wait_idle(input int b);
        logic [7:0] s;
        int k;
        for (k = 0; k < 400; k++) begin
            rd_reg(ADDR_CHANNEL_STATUS, s);
            if (s[b] === 1'b0) break;
        end
        if (k == 400) begin
            num_errors++;
            $display("ERROR busy expected 0 seen 1");
            end_of_test();
        end
        repeat (2) @(posedge clk);
    endtask

    // ----------------------------
    // Bus model and random stalls
    // ----------------------------
    always @(posedge clk) begin
        if (rnd_on === 1'b1) begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            stall <= seed[15:0] & 16'h0006;
        end
        if (take === 1'b1 && src_id == 4'h3) take_cnt++;
        if (take === 1'b1 && src_id !== 4'h3) begin
            chk("source id", {12'h0, cur_src}, {12'h0, src_id});
        end
        if (put === 1'b1) begin
            chk("dest id", {12'h0, cur_dst}, {12'h0, dst_id});
            chk("data", {8'h00, exp_byte(cur_src)}, {8'h00, wr_data});
            if (crc_on) crc_m = crc_step(crc_m, exp_byte(cur_src));
            exp_cnt[cur_src]++;
            put_cnt++;
        end
    end

    initial begin
        logic [7:0] h, l;
        rnd_on = 1'b0;
        crc_on = 1'b0;
        cur_src = 4'h1;
        cur_dst = 4'h2;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd_reg(ADDR_CRC_DATA, h);
        rd_reg(ADDR_CRC_DATA, l);
        chk("crc reset", 16'h0000, {h, l});
        rd_reg(3'h7, h);
        chk("unmapped", 16'h0000, {8'h00, h});
        desc(ADDR_CHAN0_DESC, 8'h01, 8'h02, 8'h00, 16'h0001);
        rd_reg(ADDR_CHANNEL_STATUS, h);
        chk("disabled busy", 16'h0000, {14'h0, h[1:0]});
        wr_reg(ADDR_FLOW_CONTROL, 8'h03);
        wr_reg(ADDR_CHANNEL_CONTROL, 8'h02);
        rd_reg(ADDR_CHANNEL_CONTROL, h);
        chk("idle abort", 16'h0000, {14'h0, h[1:0]});
        $display("test reset done");
        wr_reg(ADDR_CRC_DATA, 8'h12);
        wr_reg(ADDR_CRC_DATA, 8'h34);
        crc_m = 16'h1234;
        crc_on = 1'b1;
        rnd_on = 1'b1;
        wr_reg(ADDR_CHANNEL_CONTROL, 8'h10);
        desc(ADDR_CHAN0_DESC, 8'h01, 8'h02, 8'h02, 16'h0003);
        rd_reg(ADDR_CHANNEL_STATUS, h);
        chk("busy0", 16'h0001, {15'h0, h[0]});
        wait_idle(0);
        rnd_on = 1'b0;
        stall <= 16'h0000;
        chk("bytes", 16'd12, put_cnt[15:0]);
        rd_reg(ADDR_CHANNEL_STATUS, h);
        chk("eof0", 16'h0001, {15'h0, h[2]});
        chk("irq", 16'h0001, {14'h0, eof_irq});
        rd_reg(ADDR_CRC_DATA, h);
        rd_reg(ADDR_CRC_DATA, l);
        chk("crc", crc_m, {h, l});
        wr_reg(ADDR_CHANNEL_CONTROL, 8'h14);
        rd_reg(ADDR_CHANNEL_STATUS, h);
        chk("ack0", 16'h0000, {15'h0, h[2]});
        $display("test flow done");
        rd_reg(ADDR_CRC_DATA, h);
        crc_on = 1'b0;
        wr_reg(ADDR_FLOW_CONTROL, 8'h01);
        rd_reg(ADDR_CRC_DATA, l);
        chk("crc restart", {8'h00, crc_m[15:8]}, {8'h00, l});
        wr_reg(ADDR_CHAN1_DESC, 8'h03);
        wr_reg(ADDR_CHAN1_DESC, 8'h0F);
        wr_reg(ADDR_CHANNEL_CONTROL, 8'h02);
        rd_reg(ADDR_CHANNEL_STATUS, h);
        chk("partial eof1", 16'h0000, {14'h0, h[3], h[1]});
        put_cnt = 0;
        take_cnt = 0;
        desc(ADDR_CHAN0_DESC, 8'h01, 8'h02, 8'h00, 16'h0010);
        desc(ADDR_CHAN1_DESC, 8'h03, 8'h0F, 8'h00, 16'h0003);
        wait_idle(1);
        wait_idle(0);
        chk("null takes", 16'd3, take_cnt[15:0]);
        chk("null puts", 16'd16, put_cnt[15:0]);
        rd_reg(ADDR_CHANNEL_STATUS, h);
        chk("eof1", 16'h0001, {15'h0, h[3]});
        wr_reg(ADDR_CHANNEL_CONTROL, 8'h0C);
        wr_reg(ADDR_FLOW_CONTROL, 8'h11);
        cur_src = 4'hF;
        put_cnt = 0;
        desc(ADDR_CHAN1_DESC, 8'h0F, 8'h02, 8'h00, 16'h0002);
        wait_idle(1);
        chk("null source", 16'd2, put_cnt[15:0]);
        cur_src = 4'h1;
        wr_reg(ADDR_CHANNEL_CONTROL, 8'h08);
        $display("test null done");
        for (int m = 0; m < 2; m++) begin
            wr_reg(ADDR_FLOW_CONTROL, (m == 1) ? 8'h0D : 8'h09);
            stall <= 16'h0004;
            put_cnt = 0;
            desc(ADDR_CHAN0_DESC, 8'h01, 8'h02, 8'h02, 16'h0100);
            rd_reg(ADDR_CHANNEL_STATUS, h);
            chk("ready", 16'h0001, {14'h0, h[5:4]});
            stall <= 16'h0000;
            repeat (9) @(posedge clk);
            wr_reg(ADDR_CHANNEL_CONTROL, 8'h01);
            wait_idle(0);
            rd_reg(ADDR_CHANNEL_STATUS, h);
            chk("abort eof0", 16'h0001, {15'h0, h[2]});
            if (m == 1) begin
                chk("whole packets", 16'h0000, {14'h0, put_cnt[1:0]});
                rd_reg(ADDR_CHAN0_DESC, h);
                rd_reg(ADDR_CHAN0_DESC, l);
                chk("remaining", 16'(256 - put_cnt / 4), {h, l});
            end
            wr_reg(ADDR_CHANNEL_CONTROL, 8'h04);
        end
        $display("test abort done");
        end_of_test();
    end
endmodule
